/* bench/serp_master_model.sv */
// two-wire bus master model driving clock and open-drain data
`timescale 1ns/1ns
module serp_master_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_m
);
   initial begin
      scl = 1'h1;
      sda_m = 1'h1;
   end
   // 5 clk half bit keeps scl above the 4 clk minimum each phase
   task automatic hb();
      repeat (5) @(posedge clk);
   endtask
   // data only moves while scl is low, away from its edges
   task automatic bit_io(input logic b, output logic r);
      sda_m <= b;
      hb();
      scl <= 1'h1;
      hb();
      r = sda_line;
      scl <= 1'h0;
      hb();
   endtask
   task automatic start();
      sda_m <= 1'h1;
      hb();
      scl <= 1'h1;
      hb();
      sda_m <= 1'h0;
      hb();
      scl <= 1'h0;
      hb();
   endtask
   task automatic stop();
      sda_m <= 1'h0;
      hb();
      scl <= 1'h1;
      hb();
      sda_m <= 1'h1;
      hb();
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'h1, ack);
   endtask
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'h1, d[i]);
      end
      bit_io(nack, r);
   endtask
endmodule

/* bench/tb_top.sv */
// self-checking bench for the serial eeprom read port
`timescale 1ns/1ns
module tb_top;
   import serp_pkg::*;
   logic               clk = 1'h0;
   logic               rst_n = 1'h0;
   logic               init_we = 1'h0;
   logic [SERP_AW-1:0] init_addr = 4'h0;
   logic [SERP_DW-1:0] init_data = 8'h00;
   logic               scl, sda_m, sda_out, sda_oe, busy, ak;
   logic [SERP_AW-1:0] addr_ptr;
   logic [SERP_DW-1:0] d;
   // pull-up: released line reads high
   wire                sda_line = sda_m & (~sda_oe | sda_out);
   int                 fail_count = 0;
   int                 n_checks = 0;
   always #5 clk = ~clk;
   serp_master_model M (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
   serp_read_port DUT (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .init_we(init_we), .init_addr(init_addr), .init_data(init_data),
      .addr_ptr(addr_ptr), .busy(busy));
   function automatic logic [7:0] pat(input int a);
      return 8'(a * 29 + 90);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic ctrl(input logic rd);
      M.put_byte({SERP_DEV_ADDR, rd}, ak);
      chk(ak, 0);
   endtask
   task automatic set_addr(input logic [3:0] a);
      M.start();
      ctrl(1'h0);
      M.put_byte({4'h0, a}, ak);
      chk(ak, 0);
      M.start();
      chk(addr_ptr, a);
      ctrl(1'h1);
   endtask
   task automatic t_random();
      set_addr(4'h5);
      chk(busy, 1);
      M.get_byte(1'h1, d);
      chk(d, pat(5));
      M.stop();
      chk(addr_ptr, 6);
      chk(sda_oe, 0);
      chk(busy, 0);
      $display("t_random done");
   endtask
   task automatic t_current();
      M.start();
      ctrl(1'h1);
      M.get_byte(1'h1, d);
      chk(d, pat(6));
      M.stop();
      chk(addr_ptr, 7);
      $display("t_current done");
   endtask
   task automatic t_seq();
      set_addr(4'he);
      for (int i = 0; i < 4; i++) begin
         M.get_byte(i == 3, d);
         chk(d, pat((14 + i) % 16));
      end
      M.stop();
      chk(addr_ptr, 2);
      $display("t_seq done");
   endtask
   task automatic t_refuse();
      M.start();
      M.put_byte({7'h51, 1'h1}, ak);
      chk(ak, 1);
      chk(busy, 0);
      M.stop();
      $display("t_refuse done");
   endtask
   task automatic t_write();
      M.start();
      ctrl(1'h0);
      M.put_byte(8'h09, ak);
      chk(ak, 0);
      M.put_byte(8'h3c, ak);
      chk(ak, 0);
      M.stop();
      chk(addr_ptr, 10);
      M.start();
      ctrl(1'h1);
      M.get_byte(1'h1, d);
      chk(d, pat(10));
      M.stop();
      $display("t_write done");
   endtask
   task automatic t_reset();
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      chk(addr_ptr, 0);
      chk(sda_oe, 0);
      chk(busy, 0);
      M.start();
      ctrl(1'h1);
      M.get_byte(1'h1, d);
      chk(d, pat(0));
      M.stop();
      chk(addr_ptr, 1);
      $display("t_reset done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         init_we <= 1'h1;
         init_addr <= 4'(i);
         init_data <= pat(i);
      end
      @(posedge clk);
      init_we <= 1'h0;
      t_random();
      t_current();
      t_seq();
      t_refuse();
      t_write();
      t_reset();
      results();
   end
   // whole run needs some 210 bus clocks of 15 clk each; the limit leaves a wide margin
   initial begin
      #400000;
      fail_count++;
      results();
   end
endmodule

/* src/serp_bus_if.sv */
// bus condition signals passed from the line watcher to the protocol engine
`timescale 1ns/1ns
interface serp_bus_if;
   logic start;
   logic stop;
   logic scl_rise;
   logic scl_fall;
   logic sda;
   modport watcher (output start, output stop, output scl_rise, output scl_fall, output sda);
   modport engine  (input start, input stop, input scl_rise, input scl_fall, input sda);
endinterface

/* src/serp_line_watch.sv */
// edge and start/stop detector on the two bus lines
`timescale 1ns/1ns
module serp_line_watch (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic scl_in,
   input  wire logic sda_in,
   serp_bus_if.watcher bus
);
   logic scl_r;
   logic sda_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_r <= 1'h1;
         sda_r <= 1'h1;
      end else begin
         scl_r <= scl_in;
         sda_r <= sda_in;
      end
   end

   // sda changing while scl high marks start (falling) or stop (rising)
   assign bus.start    = scl_r & scl_in & sda_r & ~sda_in;
   assign bus.stop     = scl_r & scl_in & ~sda_r & sda_in;
   assign bus.scl_rise = ~scl_r & scl_in;
   assign bus.scl_fall = scl_r & ~scl_in;
   assign bus.sda      = sda_in;
endmodule

/* src/serp_pkg.sv */
// constants and types shared by the serial eeprom read port
package serp_pkg;
   localparam int unsigned SERP_DEPTH       = 16;
   localparam int unsigned SERP_AW          = 4;
   localparam int unsigned SERP_DW          = 8;
   localparam logic [6:0]  SERP_DEV_ADDR    = 7'h50;
   localparam logic        SERP_DIR_READ    = 1'h1;
   localparam logic [3:0]  SERP_BIT_LAST    = 4'h7;
   localparam logic [3:0]  SERP_BIT_ACK     = 4'h8;
   localparam logic [3:0]  SERP_ADDR_RST    = 4'h0;
   localparam logic [3:0]  SERP_ADDR_STEP   = 4'h1;

   typedef enum logic [2:0] {
      SERP_IDLE  = 3'b000,
      SERP_CTRL  = 3'b001,
      SERP_WADDR = 3'b010,
      SERP_WDATA = 3'b011,
      SERP_RDATA = 3'b100,
      SERP_RACK  = 3'b101
   } serp_state_t;
endpackage

/* src/serp_read_port.sv */
// read port of the 16 byte serial data eeprom
// Contract
// RL1 - read starts like write, direction bit one
// RL2 - counter keeps last address, next read n+1
// RL3 - address match with read: ack, send byte
// RL4 - master nack then stop ends; release data
// RL5 - master loads word address by write first
// RL6 - repeated start abandons write, keeps pointer
// RL7 - master resends control byte with read bit
// RL8 - after random read pointer follows returned byte
// RL9 - master ack gets next sequential byte
// RL10 - pointer increments by one per read
// RL11 - array holds 16 bytes, pointer covers them
// RL12 - pointer wraps past last location to zero
`timescale 1ns/1ns
module serp_read_port
   import serp_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   input  wire logic               init_we,
   input  wire logic [SERP_AW-1:0] init_addr,
   input  wire logic [SERP_DW-1:0] init_data,
   output logic [SERP_AW-1:0]      addr_ptr,
   output logic                    busy
);
   serp_bus_if bus ();

   serp_line_watch u_watch (
      .clk    (clk),
      .rst_n  (rst_n),
      .scl_in (scl_in),
      .sda_in (sda_in),
      .bus    (bus)
   );

   // array contents come from the write side, modelled here by a load port
   logic [SERP_DW-1:0] mem [SERP_DEPTH];  // [RL11]

   serp_state_t        state_r, state_nxt;
   logic [3:0]         bit_r;
   logic [SERP_DW-1:0] sh_r;
   logic [SERP_AW-1:0] ptr_r;
   logic               drv_r;
   logic               out_r;

   function automatic logic [SERP_AW-1:0] step(input logic [SERP_AW-1:0] a);
      step = a + SERP_ADDR_STEP;  // natural 4 bit overflow wraps 15 to 0 [RL12]
   endfunction

   wire ctrl_hit  = (sh_r[7:1] == SERP_DEV_ADDR);
   wire byte_done = bus.scl_rise && (bit_r == SERP_BIT_LAST);
   wire ack_slot  = (bit_r == SERP_BIT_ACK);
   wire is_read   = sh_r[0] == SERP_DIR_READ;  // [RL1]
   // the ninth rise is the ack clock; the fall before it opens the ack slot
   wire ack_rise  = bus.scl_rise && ack_slot;
   // idle never acks, so a foreign address or a finished read stays silent
   wire ack_drive = ack_slot && (state_r == SERP_CTRL ? ctrl_hit : (state_r == SERP_WADDR || state_r == SERP_WDATA));

   always_ff @(posedge clk) begin
      if (init_we)
         mem[init_addr] <= init_data;
   end

   always_comb begin
      state_nxt = state_r;
      if (bus.stop)
         state_nxt = SERP_IDLE;  // [RL4]
      else if (bus.start)
         state_nxt = SERP_CTRL;  // a repeated start drops any write in flight [RL6]
      else if (state_r == SERP_RDATA && byte_done)
         state_nxt = SERP_RACK;  // last bit stays out until the fall, then the master answers
      else if (ack_rise) begin
         case (state_r)
            SERP_CTRL: begin
               if (!ctrl_hit)
                  state_nxt = SERP_IDLE;
               else if (is_read)
                  state_nxt = SERP_RDATA;  // [RL3]
               else
                  state_nxt = SERP_WADDR;  // [RL5]
            end
            SERP_WADDR: state_nxt = SERP_WDATA;
            SERP_WDATA: state_nxt = SERP_WDATA;
            SERP_RACK:  state_nxt = bus.sda ? SERP_IDLE : SERP_RDATA;  // nack ends the read at once, ack goes on to the next byte [RL4] [RL9]
            default:    state_nxt = state_r;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         state_r <= SERP_IDLE;
      else
         state_r <= state_nxt;
   end

   // bit counter: counts rises; eight data bits, then the ack rise closes the frame
   always_ff @(posedge clk) begin
      if (!rst_n || bus.start || bus.stop)
         bit_r <= 4'h0;
      else if (ack_rise)
         bit_r <= 4'h0;
      else if (bus.scl_rise)
         bit_r <= bit_r + 4'h1;
   end

   // receive shift register for control and address bytes
   always_ff @(posedge clk) begin
      if (!rst_n)
         sh_r <= 8'h00;
      else if (bus.scl_rise && bit_r < SERP_BIT_ACK && state_r != SERP_RDATA)
         sh_r <= {sh_r[6:0], bus.sda};
   end

   // pointer: loaded by the word address, stepped once per byte sent and once per write data byte received
   always_ff @(posedge clk) begin
      if (!rst_n)
         ptr_r <= SERP_ADDR_RST;
      else if (state_r == SERP_WADDR && byte_done)
         ptr_r <= {sh_r[2:0], bus.sda};  // kept even if a restart follows [RL6]
      else if (state_r == SERP_WDATA && byte_done)
         ptr_r <= step(ptr_r);  // write data itself belongs to the write side
      else if (state_r == SERP_RDATA && byte_done)
         ptr_r <= step(ptr_r);  // [RL2] [RL8] [RL10]
   end

   // data drive: ack low, then msb first from the pointed location
   logic [2:0] bsel;
   assign bsel = 3'(SERP_BIT_LAST - bit_r);
   wire rd_bit = mem[ptr_r][bsel];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drv_r <= 1'h0;
         out_r <= 1'h1;
      end else if (bus.start || bus.stop) begin
         drv_r <= 1'h0;  // [RL4]
         out_r <= 1'h1;
      end else if (bus.scl_fall) begin
         if (ack_drive) begin
            drv_r <= 1'h1;  // acknowledge slot
            out_r <= 1'h0;
         end else if (state_r == SERP_RDATA && bit_r <= SERP_BIT_LAST) begin
            drv_r <= 1'h1;  // msb first, changed only while scl is low [RL3] [RL9]
            out_r <= rd_bit;
         end else begin
            drv_r <= 1'h0;  // release for the master's ack bit
            out_r <= 1'h1;
         end
      end
   end

   assign sda_out  = out_r;
   assign sda_oe   = drv_r;
   assign addr_ptr = ptr_r;
   assign busy     = (state_r != SERP_IDLE);

   property p_wrap;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_RDATA && byte_done && ptr_r == 4'hf) |=> ptr_r == 4'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("pointer did not wrap");  // [RL12]

   property p_step;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_RDATA && byte_done && !bus.start && !bus.stop) |=> ptr_r == $past(ptr_r) + 4'h1;
   endproperty
   a_step: assert property (p_step) else $error("pointer not stepped after read");  // [RL10]

   property p_release;
      @(posedge clk) disable iff (!rst_n)
      bus.stop |=> !sda_oe;
   endproperty
   a_release: assert property (p_release) else $error("data still driven after stop");  // [RL4]

   property p_keep;
      @(posedge clk) disable iff (!rst_n)
      bus.start |=> ptr_r == $past(ptr_r);
   endproperty
   a_keep: assert property (p_keep) else $error("pointer lost on restart");  // [RL6]

   property p_rd_enter;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_CTRL && bus.scl_rise && ack_slot && ctrl_hit && is_read && !bus.start && !bus.stop)
      |=> state_r == SERP_RDATA;
   endproperty
   a_rd_enter: assert property (p_rd_enter) else $error("read not entered");  // [RL3]

   property p_nack_idle;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_RACK && bus.scl_rise && bus.sda && !bus.start && !bus.stop) |=> state_r == SERP_IDLE;
   endproperty
   a_nack_idle: assert property (p_nack_idle) else $error("nack did not end read");  // [RL4]

   property p_seq;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_RACK && bus.scl_rise && !bus.sda && !bus.start && !bus.stop) |=> state_r == SERP_RDATA;
   endproperty
   a_seq: assert property (p_seq) else $error("ack did not continue read");  // [RL9]

   property p_load;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_WADDR && byte_done && !bus.start && !bus.stop) |=> ptr_r[0] == $past(bus.sda);
   endproperty
   a_load: assert property (p_load) else $error("word address not loaded");  // [RL5]

   property p_ack;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_CTRL && bus.scl_fall && ack_slot && ctrl_hit && !bus.start && !bus.stop)
      |=> sda_oe && !sda_out;
   endproperty
   a_ack: assert property (p_ack) else $error("own address not acknowledged");  // [RL3]

   property p_refuse;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_CTRL && bus.scl_fall && ack_slot && !ctrl_hit && !bus.start && !bus.stop)
      |=> !sda_oe;
   endproperty
   a_refuse: assert property (p_refuse) else $error("foreign address acknowledged");  // [RL3]

   property p_idle_quiet;
      @(posedge clk) disable iff (!rst_n)
      (state_r == SERP_IDLE && bus.scl_fall && !bus.start && !bus.stop) |=> !sda_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("data driven while idle");  // [RL4]
endmodule
